// >>> verilog/qos_cfg_pkg.sv
// constants shared by the switch qos and snoop configuration bank
package qos_cfg_pkg;

    // ========================================================
    // bus geometry
    localparam int         ADDR_W       = 12;
    localparam int         DATA_W       = 32;
    localparam int         IDX_W        = 10;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_MAP_3A   = 10'h35d;
    localparam logic [9:0] IDX_MAP_3C   = 10'h35e;
    localparam logic [9:0] IDX_MAP_3E   = 10'h35f;
    localparam logic [9:0] IDX_MIRROR   = 10'h370;
    localparam logic [9:0] IDX_COLOUR   = 10'h378;
    localparam logic [9:0] IDX_PTP_EV   = 10'h37c;
    localparam logic [9:0] IDX_PTP_GEN  = 10'h37d;

    // ========================================================
    // writable bits and reset values
    localparam logic [7:0] MASK_MAP     = 8'h77;
    localparam logic [7:0] MASK_MIRROR  = 8'h4d;
    localparam logic [7:0] MASK_COLOUR  = 8'h3f;
    localparam logic [7:0] MASK_PTP     = 8'h8f;
    localparam logic [7:0] RST_MAP      = 8'h00;
    localparam logic [7:0] RST_MIRROR   = 8'h00;
    localparam logic [7:0] RST_COLOUR   = 8'h39;
    localparam logic [7:0] RST_PTP      = 8'h0f;

    // ========================================================
    // field positions
    localparam int         IGMP_EN_BIT  = 6;
    localparam int         MLD_OPT_BIT  = 3;
    localparam int         MLD_EN_BIT   = 2;
    localparam int         SNIFF_AND_BIT = 0;
    localparam int         PTP_OVR_BIT  = 7;
    localparam int         PRIO_W       = 3;
    localparam int         QPRIO_W      = 4;

    // ========================================================
    // dscp range held here and ipv6 next header codes
    localparam logic [5:0] DSCP_FIRST   = 6'h3a;
    localparam logic [7:0] NH_HOP       = 8'h00;
    localparam logic [7:0] NH_ICMP4     = 8'h01;
    localparam logic [7:0] NH_ICMP6     = 8'h3a;
    localparam logic [7:0] NH_ROUTE     = 8'h2b;
    localparam logic [7:0] NH_FRAG      = 8'h2c;
    localparam logic [7:0] NH_ESP       = 8'h32;
    localparam logic [7:0] NH_AUTH      = 8'h33;
    localparam logic [7:0] NH_DEST      = 8'h3c;

endpackage

// >>> verilog/nh_match_if.sv
// carrier between the bank and one next header checker
`timescale 1ns/1ps
interface nh_match_if;
    logic [7:0] next_hdr;
    logic       alt_set;
    logic       hit;
    modport src (output next_hdr, output alt_set, input hit);
    modport chk (input next_hdr, input alt_set, output hit);
endinterface

// >>> verilog/nh_match.sv
// checks one ipv6 next header code against the selected snoop set
`timescale 1ns/1ps
module nh_match
(
    nh_match_if.chk m
);
    import qos_cfg_pkg::*;

    // ========================================================
    // set selection
    always_comb
    begin
        if (m.alt_set)
        begin
            m.hit = (m.next_hdr == NH_ROUTE) || (m.next_hdr == NH_FRAG) ||
                    (m.next_hdr == NH_ESP) || (m.next_hdr == NH_AUTH) ||
                    (m.next_hdr == NH_DEST);
        end
        else
        begin
            m.hit = (m.next_hdr == NH_ICMP4) || (m.next_hdr == NH_ICMP6);
        end
    end
endmodule

// >>> verilog/switch_qos_snoop_config.sv
// switch qos, snoop and timing priority configuration bank
//
// Operation
// - 0x035D holds priorities for dscp 0x3A, 0x3B
// - 0x035E holds priorities for dscp 0x3C, 0x3D
// - 0x035F holds priorities for dscp 0x3E, 0x3F
// - igmp enable sends igmp packets to host
// - mld enable sends mld packets to host
// - option clear: headers 1 or 58 match
// - option set: headers 43,44,50,51,60 match
// - sniff select set: source and destination match
// - sniff select clear: source or destination match
// - red colour value bits 5:4, reset 11b
// - yellow 10b, green 01b colour values
// - event override clear: qos priority used
// - event override set: field priority used
// - general override clear: qos priority used
// - general override set: field priority used
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module switch_qos_snoop_config
(
    // clock, reset, enable
    input  wire logic                             ref_clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             ce_i,
    // axi4-lite write address
    input  wire logic                             s_axi_awvalid_i,
    output logic                                  s_axi_awready_o,
    input  wire logic [qos_cfg_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
    // axi4-lite write data
    input  wire logic                             s_axi_wvalid_i,
    output logic                                  s_axi_wready_o,
    input  wire logic [qos_cfg_pkg::DATA_W-1:0]   s_axi_wdata_i,
    input  wire logic [3:0]                       s_axi_wstrb_i,
    // axi4-lite write response
    output logic                                  s_axi_bvalid_o,
    input  wire logic                             s_axi_bready_i,
    output logic [1:0]                            s_axi_bresp_o,
    // axi4-lite read address
    input  wire logic                             s_axi_arvalid_i,
    output logic                                  s_axi_arready_o,
    input  wire logic [qos_cfg_pkg::ADDR_W-1:0]   s_axi_araddr_i,
    // axi4-lite read data
    output logic                                  s_axi_rvalid_o,
    input  wire logic                             s_axi_rready_i,
    output logic [qos_cfg_pkg::DATA_W-1:0]        s_axi_rdata_o,
    output logic [1:0]                            s_axi_rresp_o,
    // frame classification request
    input  wire logic                             cls_valid_i,
    input  wire logic [5:0]                       dscp_i,
    input  wire logic                             pkt_igmp_i,
    input  wire logic                             pkt_ipv6_i,
    input  wire logic [7:0]                       next_hdr_i,
    input  wire logic [7:0]                       hbh_next_hdr_i,
    input  wire logic                             src_port_match_i,
    input  wire logic                             dst_port_match_i,
    input  wire logic                             ptp_event_i,
    input  wire logic                             ptp_general_i,
    input  wire logic [qos_cfg_pkg::QPRIO_W-1:0]  qos_prio_i,
    // classification result
    output logic                                  res_valid_o,
    output logic                                  dscp_hit_o,
    output logic [qos_cfg_pkg::PRIO_W-1:0]        dscp_prio_o,
    output logic                                  to_host_o,
    output logic                                  sniff_o,
    output logic [qos_cfg_pkg::QPRIO_W-1:0]       queue_prio_o,
    // drop colour values
    output logic [1:0]                            red_dscp_o,
    output logic [1:0]                            yellow_dscp_o,
    output logic [1:0]                            green_dscp_o
);
    import qos_cfg_pkg::*;

    // ========================================================
    // state
    typedef struct packed {
        // register bank
        logic [7:0]         map_3a;
        logic [7:0]         map_3c;
        logic [7:0]         map_3e;
        logic [7:0]         mirror;
        logic [7:0]         colour;
        logic [7:0]         ptp_ev;
        logic [7:0]         ptp_gen;
        // write channel
        logic               aw_held;
        logic [IDX_W-1:0]   aw_idx;
        logic               w_held;
        logic [7:0]         w_data;
        logic               w_en;
        logic               bvalid;
        logic [1:0]         bresp;
        // read channel
        logic               rvalid;
        logic [1:0]         rresp;
        logic [7:0]         rdata;
        // classification result
        logic               res_valid;
        logic               dscp_hit;
        logic [PRIO_W-1:0]  dscp_prio;
        logic               to_host;
        logic               sniff;
        logic [QPRIO_W-1:0] queue_prio;
    } state_s;

    localparam state_s RST_S = '{
        map_3a:  RST_MAP,
        map_3c:  RST_MAP,
        map_3e:  RST_MAP,
        mirror:  RST_MIRROR,
        colour:  RST_COLOUR,
        ptp_ev:  RST_PTP,
        ptp_gen: RST_PTP,
        aw_held: 1'b0,
        aw_idx:  '0,
        w_held:  1'b0,
        w_data:  8'h00,
        w_en:    1'b0,
        bvalid:  1'b0,
        bresp:   RESP_OKAY,
        rvalid:  1'b0,
        rresp:   RESP_OKAY,
        rdata:   8'h00,
        res_valid:  1'b0,
        dscp_hit:   1'b0,
        dscp_prio:  '0,
        to_host:    1'b0,
        sniff:      1'b0,
        queue_prio: '0
    };

    state_s r;
    state_s n;

    // ========================================================
    // next header checkers
    nh_match_if nh_first ();
    nh_match_if nh_hop ();

    assign nh_first.next_hdr = next_hdr_i;
    assign nh_first.alt_set  = r.mirror[MLD_OPT_BIT];
    assign nh_hop.next_hdr   = hbh_next_hdr_i;
    assign nh_hop.alt_set    = r.mirror[MLD_OPT_BIT];

    nh_match u_nh_first
    (
        .m (nh_first.chk)
    );

    nh_match u_nh_hop
    (
        .m (nh_hop.chk)
    );

    // ========================================================
    // handshakes
    // a held half blocks its own channel, an unanswered write blocks both write channels
    // clock enable low freezes the bank, so no channel is taken then
    assign s_axi_awready_o = ce_i && !r.aw_held && !r.bvalid;
    assign s_axi_wready_o  = ce_i && !r.w_held && !r.bvalid;
    assign s_axi_arready_o = ce_i && !r.rvalid;

    // ========================================================
    // read decode
    // bit 8 marks a mapped index, unmapped reads answer zero
    function automatic logic [8:0] read_reg
    (
        input state_s          s,
        input logic [IDX_W-1:0] idx
    );
        logic [8:0] v;
        v = 9'h000;
        case (idx)
            IDX_MAP_3A:  v = {1'b1, s.map_3a};
            IDX_MAP_3C:  v = {1'b1, s.map_3c};
            IDX_MAP_3E:  v = {1'b1, s.map_3e};
            IDX_MIRROR:  v = {1'b1, s.mirror};
            IDX_COLOUR:  v = {1'b1, s.colour};
            IDX_PTP_EV:  v = {1'b1, s.ptp_ev};
            IDX_PTP_GEN: v = {1'b1, s.ptp_gen};
            default:     v = 9'h000;
        endcase
        return v;
    endfunction

    // ========================================================
    // next state
    always_comb
    begin
        logic [8:0]  rd;
        logic        wr_hit;
        logic [8:0]  wr_chk;
        logic [5:0]  dscp_off;
        logic [7:0]  map_sel;
        logic        mld_hit;
        logic [7:0]  ptp_reg;
        rd       = 9'h000;
        wr_hit   = 1'b0;
        wr_chk   = 9'h000;
        dscp_off = 6'h00;
        map_sel  = 8'h00;
        mld_hit  = 1'b0;
        ptp_reg  = 8'h00;
        n        = r;

        // ========================================================
        // address and data may arrive in either order
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            n.aw_held = 1'b1;
            n.aw_idx  = s_axi_awaddr_i[IDX_W+1:2];
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            n.w_held = 1'b1;
            n.w_data = s_axi_wdata_i[7:0];
            n.w_en   = s_axi_wstrb_i[0];
        end

        // ========================================================
        // whole byte lands in one edge
        // frames classified in this cycle still see the old byte
        if (r.aw_held && r.w_held)
        begin
            wr_chk    = read_reg(r, r.aw_idx);
            wr_hit    = wr_chk[8];
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (r.w_en)
            begin
                case (r.aw_idx)
                    IDX_MAP_3A:  n.map_3a  = r.w_data & MASK_MAP;
                    IDX_MAP_3C:  n.map_3c  = r.w_data & MASK_MAP;
                    IDX_MAP_3E:  n.map_3e  = r.w_data & MASK_MAP;
                    IDX_MIRROR:  n.mirror  = r.w_data & MASK_MIRROR;
                    IDX_COLOUR:  n.colour  = r.w_data & MASK_COLOUR;
                    IDX_PTP_EV:  n.ptp_ev  = r.w_data & MASK_PTP;
                    IDX_PTP_GEN: n.ptp_gen = r.w_data & MASK_PTP;
                    default:     n.mirror  = r.mirror;
                endcase
            end
        end
        if (r.bvalid && s_axi_bready_i)
        begin
            n.bvalid = 1'b0;
        end

        // ========================================================
        // read answers one cycle after the address is taken
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rd       = read_reg(r, s_axi_araddr_i[IDX_W+1:2]);
            n.rvalid = 1'b1;
            n.rdata  = rd[7:0];
            n.rresp  = rd[8] ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r.rvalid && s_axi_rready_i)
        begin
            n.rvalid = 1'b0;
        end

        // ========================================================
        // dscp lookup, even code in the low field
        n.res_valid = cls_valid_i;
        dscp_off    = dscp_i - DSCP_FIRST;
        case (dscp_off[2:1])
            2'h0:    map_sel = r.map_3a;
            2'h1:    map_sel = r.map_3c;
            default: map_sel = r.map_3e;
        endcase
        n.dscp_hit  = cls_valid_i && (dscp_i >= DSCP_FIRST);
        n.dscp_prio = dscp_off[0] ? map_sel[6:4] : map_sel[2:0];

        // ========================================================
        // snooping toward the host port
        mld_hit = nh_first.hit || ((next_hdr_i == NH_HOP) && nh_hop.hit);
        n.to_host = cls_valid_i &&
                    ((pkt_igmp_i && r.mirror[IGMP_EN_BIT]) ||
                     (pkt_ipv6_i && r.mirror[MLD_EN_BIT] && mld_hit));

        // ========================================================
        // sniff filter
        if (r.mirror[SNIFF_AND_BIT])
        begin
            n.sniff = cls_valid_i && src_port_match_i && dst_port_match_i;
        end
        else
        begin
            n.sniff = cls_valid_i && (src_port_match_i || dst_port_match_i);
        end

        // ========================================================
        // timing message priority override
        ptp_reg = ptp_event_i ? r.ptp_ev : r.ptp_gen;
        if ((ptp_event_i || ptp_general_i) && ptp_reg[PTP_OVR_BIT])
        begin
            n.queue_prio = ptp_reg[QPRIO_W-1:0];
        end
        else
        begin
            n.queue_prio = qos_prio_i;
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r <= RST_S;
        end
        else if (ce_i)
        begin
            r <= n;
        end
    end

    // ========================================================
    // outputs
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_bresp_o  = r.bresp;
    assign s_axi_rvalid_o = r.rvalid;
    assign s_axi_rdata_o  = {24'h000000, r.rdata};
    assign s_axi_rresp_o  = r.rresp;

    // classification results
    assign res_valid_o    = r.res_valid;
    assign dscp_hit_o     = r.dscp_hit;
    assign dscp_prio_o    = r.dscp_prio;
    assign to_host_o      = r.to_host;
    assign sniff_o        = r.sniff;
    assign queue_prio_o   = r.queue_prio;

    // drop colour values straight from the register, no extra stage
    assign red_dscp_o     = r.colour[5:4];
    assign yellow_dscp_o  = r.colour[3:2];
    assign green_dscp_o   = r.colour[1:0];

endmodule

// >>> bench/qos_cfg_asserts.sv
// concurrent checks on the qos and snoop configuration bank ports
`timescale 1ns/1ps
module qos_cfg_asserts
(
    // clock and reset
    input wire logic                            ref_clk_i,
    input wire logic                            rst_n_i,
    input wire logic                            ce_i,
    // register bus
    input wire logic                            s_axi_bvalid_o,
    input wire logic                            s_axi_bready_i,
    input wire logic [1:0]                      s_axi_bresp_o,
    input wire logic                            s_axi_rvalid_o,
    input wire logic                            s_axi_rready_i,
    input wire logic [qos_cfg_pkg::DATA_W-1:0]  s_axi_rdata_o,
    // classification
    input wire logic                            cls_valid_i,
    input wire logic [5:0]                      dscp_i,
    input wire logic                            pkt_igmp_i,
    input wire logic                            pkt_ipv6_i,
    input wire logic                            src_port_match_i,
    input wire logic                            dst_port_match_i,
    input wire logic                            ptp_event_i,
    input wire logic                            ptp_general_i,
    input wire logic [qos_cfg_pkg::QPRIO_W-1:0] qos_prio_i,
    input wire logic                            res_valid_o,
    input wire logic                            dscp_hit_o,
    input wire logic                            to_host_o,
    input wire logic                            sniff_o,
    input wire logic [qos_cfg_pkg::QPRIO_W-1:0] queue_prio_o
);
    import qos_cfg_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ========================================================
    // assertions
    AST_RES_LAT: assert property (ce_i |=> res_valid_o == $past(cls_valid_i))
        else $error("result valid not one cycle after request");
    AST_HIT_LOW: assert property (ce_i && cls_valid_i && dscp_i < 6'h3a |=> !dscp_hit_o)
        else $error("dscp below range flagged as held");
    AST_HIT_HIGH: assert property (ce_i && cls_valid_i && dscp_i >= 6'h3a |=> dscp_hit_o)
        else $error("dscp in range not flagged");
    AST_HOST_NONE: assert property (ce_i && !(cls_valid_i && (pkt_igmp_i || pkt_ipv6_i)) |=> !to_host_o)
        else $error("host forward without snoop packet");
    AST_SNIFF_NONE: assert property (ce_i && !(src_port_match_i || dst_port_match_i) |=> !sniff_o)
        else $error("sniff without port match");
    AST_SNIFF_BOTH: assert property (ce_i && cls_valid_i && src_port_match_i && dst_port_match_i |=> sniff_o)
        else $error("no sniff with both ports matching");
    AST_QOS_PASS: assert property (ce_i && !ptp_event_i && !ptp_general_i |=> queue_prio_o == $past(qos_prio_i))
        else $error("non timing frame priority altered");
    AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped before taken");

    // ========================================================
    // coverage
    COV_IGMP: cover property (ce_i && cls_valid_i && pkt_igmp_i ##1 to_host_o);
    COV_ERR: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
    COV_OVR: cover property (ce_i && ptp_event_i ##1 queue_prio_o != $past(qos_prio_i));
endmodule

bind switch_qos_snoop_config qos_cfg_asserts qos_cfg_asserts_i (.*);

// >>> bench/switch_qos_snoop_config_tb.sv
// self-checking bench for the qos and snoop configuration bank
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module switch_qos_snoop_config_tb;
    import qos_cfg_pkg::*;

    // ========================================================
    // stimulus and observed signals
    logic        ref_clk_i = 0, rst_n_i = 0, ce_i = 1;
    logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'h1, qos_prio_i = 0, queue_prio_o;
    logic        cls_valid_i = 0, pkt_igmp_i = 0, pkt_ipv6_i = 0, ptp_event_i = 0, ptp_general_i = 0;
    logic        src_port_match_i = 0, dst_port_match_i = 0;
    logic [5:0]  dscp_i = 0;
    logic [7:0]  next_hdr_i = 0, hbh_next_hdr_i = 0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic        res_valid_o, dscp_hit_o, to_host_o, sniff_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, red_dscp_o, yellow_dscp_o, green_dscp_o;
    logic [2:0]  dscp_prio_o;
    int          miscompares = 0, check_count = 0;
    logic [9:0]  ix[7] = '{IDX_MAP_3A, IDX_MAP_3C, IDX_MAP_3E, IDX_MIRROR, IDX_COLOUR, IDX_PTP_EV, IDX_PTP_GEN};
    logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h39, 8'h0f, 8'h0f};
    logic [7:0]  mk[7] = '{8'h77, 8'h77, 8'h77, 8'h4d, 8'h3f, 8'h8f, 8'h8f};
    // mirror, next header, hop next header, {igmp, ipv6, expected}
    logic [31:0] sn[15] = '{32'h00000004, 32'h40000005, 32'h04010003, 32'h043a0003, 32'h04003a03,
        32'h042b0002, 32'h003a0002, 32'h0c2b0003, 32'h0c2c0003, 32'h0c320003, 32'h0c330003,
        32'h0c3c0003, 32'h0c003303, 32'h0c3a0002, 32'h0c000102};
    // {mode, source, destination, expected}
    logic [3:0]  st[7] = '{4'h5, 4'h3, 4'h7, 4'hc, 4'ha, 4'hf, 4'h0};

    switch_qos_snoop_config switch_qos_snoop_config_i (.*);

    always #25 ref_clk_i = ~ref_clk_i;

    // ========================================================
    // closing report
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ========================================================
    // register bus master
    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge ref_clk_i);
        s_axi_awaddr_i <= {a, 2'h0};
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        repeat (40)
        begin
            @(negedge ref_clk_i);
            ta = s_axi_awvalid_i & s_axi_awready_o;
            tw = s_axi_wvalid_i & s_axi_wready_o;
            tb = s_axi_bvalid_o;
            r = s_axi_bresp_o;
            @(posedge ref_clk_i);
            if (ta) s_axi_awvalid_i <= 1'b0;
            if (tw) s_axi_wvalid_i <= 1'b0;
            if (tb)
            begin
                s_axi_bready_i <= 1'b0;
                `CHK(r, er)
                return;
            end
        end
        miscompares++;
        stop_test();
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tb;
        logic [31:0] q;
        logic [1:0] r;
        @(posedge ref_clk_i);
        s_axi_araddr_i <= {a, 2'h0};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        repeat (40)
        begin
            @(negedge ref_clk_i);
            ta = s_axi_arvalid_i & s_axi_arready_o;
            tb = s_axi_rvalid_o;
            q = s_axi_rdata_o;
            r = s_axi_rresp_o;
            @(posedge ref_clk_i);
            if (ta) s_axi_arvalid_i <= 1'b0;
            if (tb)
            begin
                s_axi_rready_i <= 1'b0;
                `CHK(q, {24'h0, d})
                `CHK(r, er)
                return;
            end
        end
        miscompares++;
        stop_test();
    endtask

    // one classification request, results settled on return
    task automatic go(input logic [5:0] ds, input logic [7:0] nh, input logic [7:0] hb, input logic [5:0] f);
        @(posedge ref_clk_i);
        {pkt_igmp_i, pkt_ipv6_i, src_port_match_i, dst_port_match_i, ptp_event_i, ptp_general_i} <= f;
        dscp_i <= ds;
        next_hdr_i <= nh;
        hbh_next_hdr_i <= hb;
        cls_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        cls_valid_i <= 1'b0;
        #1;
    endtask

    // ========================================================
    // tests
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK({red_dscp_o, yellow_dscp_o, green_dscp_o}, 6'h39)
        foreach (ix[i]) rd(ix[i], rv[i], RESP_OKAY);
        $display("reset test done");
        foreach (ix[i]) wr(ix[i], 8'hff, RESP_OKAY);
        foreach (ix[i]) rd(ix[i], mk[i], RESP_OKAY);
        wr(10'h35c, 8'hff, RESP_SLVERR);
        rd(10'h35c, 8'h00, RESP_SLVERR);
        `CHK({red_dscp_o, yellow_dscp_o, green_dscp_o}, 6'h3f)
        @(posedge ref_clk_i) s_axi_wstrb_i <= 4'he;
        wr(IDX_COLOUR, 8'h00, RESP_OKAY);
        rd(IDX_COLOUR, 8'h3f, RESP_OKAY);
        @(posedge ref_clk_i) s_axi_wstrb_i <= 4'h1;
        $display("access test done");
        wr(IDX_MAP_3A, 8'h21, RESP_OKAY);
        wr(IDX_MAP_3C, 8'h43, RESP_OKAY);
        wr(IDX_MAP_3E, 8'h65, RESP_OKAY);
        for (int k = 0; k < 6; k++)
        begin
            go(6'h3a + 6'(k), 8'h0, 8'h0, 6'h0);
            `CHK({dscp_hit_o, dscp_prio_o}, {1'b1, 3'(k + 1)})
        end
        go(6'h39, 8'h0, 8'h0, 6'h0);
        `CHK(dscp_hit_o, 1'b0)
        $display("dscp test done");
        foreach (sn[i])
        begin
            wr(IDX_MIRROR, sn[i][31:24], RESP_OKAY);
            go(6'h0, sn[i][23:16], sn[i][15:8], {sn[i][2:1], 4'h0});
            `CHK(to_host_o, sn[i][0])
        end
        $display("snoop test done");
        foreach (st[i])
        begin
            wr(IDX_MIRROR, {7'h0, st[i][3]}, RESP_OKAY);
            go(6'h0, 8'h0, 8'h0, {2'h0, st[i][2:1], 2'h0});
            `CHK(sniff_o, st[i][0])
        end
        $display("sniff test done");
        @(posedge ref_clk_i) qos_prio_i <= 4'h3;
        wr(IDX_PTP_EV, 8'h8a, RESP_OKAY);
        wr(IDX_PTP_GEN, 8'h85, RESP_OKAY);
        go(6'h0, 8'h0, 8'h0, 6'h2);
        `CHK(queue_prio_o, 4'ha)
        go(6'h0, 8'h0, 8'h0, 6'h1);
        `CHK(queue_prio_o, 4'h5)
        wr(IDX_PTP_EV, 8'h0a, RESP_OKAY);
        wr(IDX_PTP_GEN, 8'h05, RESP_OKAY);
        go(6'h0, 8'h0, 8'h0, 6'h2);
        `CHK(queue_prio_o, 4'h3)
        go(6'h0, 8'h0, 8'h0, 6'h1);
        `CHK(queue_prio_o, 4'h3)
        $display("timing priority test done");
        @(posedge ref_clk_i) rst_n_i <= 1'b0;
        @(posedge ref_clk_i) rst_n_i <= 1'b1;
        rd(IDX_PTP_EV, 8'h0f, RESP_OKAY);
        `CHK({red_dscp_o, yellow_dscp_o, green_dscp_o}, 6'h39)
        @(posedge ref_clk_i) ce_i <= 1'b0;
        go(6'h3b, 8'h0, 8'h0, 6'h0);
        `CHK({res_valid_o, dscp_hit_o, s_axi_awready_o, s_axi_arready_o}, 4'h0)
        @(posedge ref_clk_i) ce_i <= 1'b1;
        $display("reset and enable test done");
        stop_test();
    end
endmodule
